// [inc/rfd_chan_if.sv]
// Signals between the sync controller and one channel divider gate.
`timescale 1ns/10ps
interface rfd_chan_if;
    logic sync_evt;
    logic mask;
    logic hold;
    logic div_sync;
    modport ctrl (output sync_evt, output mask, input hold, input div_sync);
    modport chan (input sync_evt, input mask, output hold, output div_sync);
endinterface : rfd_chan_if

// [inc/rfd_pkg.sv]
// Register map, field positions and reset values of the divider sync block.
package rfd_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] RFD_IDX_UPDATE = 16'h0005;
    localparam logic [15:0] RFD_IDX_LOOP_CTL = 16'h0405;
    localparam logic [15:0] RFD_IDX_RATIO = 16'h0407;
    localparam logic [15:0] RFD_IDX_POWER = 16'h0408;
    localparam logic [15:0] RFD_IDX_SYNC = 16'h0500;
    localparam logic [15:0] RFD_IDX_STATUS = 16'h0600;
    localparam logic [15:0] RFD_IDX_CMD = 16'h0601;
    localparam logic [7:0] RFD_UPDATE_CODE = 8'h01;
    // Reset values.
    localparam logic [7:0] RFD_RST_LOOP_CTL = 8'h20;
    localparam logic [7:0] RFD_RST_RATIO = 8'h44;
    localparam logic [7:0] RFD_RST_POWER = 8'h02;
    localparam logic [7:0] RFD_RST_SYNC = 8'h02;
    // Writable bits; the others keep their reset value.
    localparam logic [7:0] RFD_WM_LOOP_CTL = 8'h08;
    localparam logic [7:0] RFD_WM_RATIO = 8'hff;
    localparam logic [7:0] RFD_WM_POWER = 8'h17;
    localparam logic [7:0] RFD_WM_SYNC = 8'h37;
    // Field positions.
    localparam int RFD_LOOP_OVR = 3;
    localparam int RFD_PWR_STARTUP = 4;
    localparam int RFD_PWR_DUAL = 2;
    localparam int RFD_PWR_PD2 = 1;
    localparam int RFD_PWR_PD1 = 0;
    localparam int RFD_SYNC_MASK1 = 5;
    localparam int RFD_SYNC_MASK0 = 4;
    localparam int RFD_SYNC_SRC = 2;
    localparam int RFD_CMD_SYNC = 0;
    // Codes.
    localparam logic [3:0] RFD_RATIO_HOLD = 4'hf;
    localparam logic [1:0] RFD_AUTO_OFF = 2'h0;
    localparam logic [1:0] RFD_AUTO_FREQ = 2'h1;
    localparam logic [1:0] RFD_AUTO_PHASE = 2'h2;
endpackage : rfd_pkg

// [logic/rfd_chan_sync.sv]
// Static sync hold and sync pulse of one distribution channel divider.
`timescale 1ns/10ps
module rfd_chan_sync (
    input wire logic clk,
    input wire logic sys_rst,
    rfd_chan_if.chan ch
);
    logic synced_ff;
    logic hold_ff;
    logic div_sync_ff;
    logic take_sync;
    logic nxt_synced;

    assign take_sync = ch.sync_evt & ~ch.mask; // [RQ9]
    assign nxt_synced = synced_ff | ch.mask | take_sync; // [RQ10]
    assign ch.hold = hold_ff;
    assign ch.div_sync = div_sync_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            synced_ff <= 1'b0;
            hold_ff <= 1'b1;
            div_sync_ff <= 1'b0;
        end else begin
            synced_ff <= nxt_synced;
            hold_ff <= ~nxt_synced; // [RQ8]
            div_sync_ff <= take_sync;
        end
    end

    a_mask_ignore: assert property ( // [RQ9]
        @(posedge clk) disable iff (sys_rst)
        ch.mask |=> !ch.div_sync && !ch.hold)
        else $error("masked channel took a sync or stayed held");
    a_mask_release: assert property ( // [RQ10]
        @(posedge clk) disable iff (sys_rst)
        $rose(ch.mask) |=> !ch.hold)
        else $error("setting the mask did not release the channel");
    a_hold_wait: assert property ( // [RQ8]
        @(posedge clk) disable iff (sys_rst)
        (ch.hold && !ch.mask && !ch.sync_evt) |=> ch.hold)
        else $error("channel left static hold without a sync pulse");
endmodule : rfd_chan_sync

// [logic/rfd_divider_sync_top.sv]
// Prescaler control and output distribution sync with a Wishbone slave.
//
// Operation
// RQ1 - Ratio codes 0101 to 1001 give divide 7 to 11 and 1111 holds reset.
// RQ2 - Software changes the ratio via the hold code and two updates.
// RQ3 - Writing 0x01 to the update register at 0x0005 fires the update.
// RQ4 - The hold step may be skipped when a calibration follows the write.
// RQ5 - Unless start-up mode is set, prescalers wait powered down for feedback.
// RQ6 - The dual power-down bit powers down both prescalers together.
// RQ7 - Bit 1 powers down the second prescaler and bit 0 the first one.
// RQ8 - An unmasked channel stays in static hold until a sync pulse.
// RQ9 - The channel 1 mask releases that divider and ignores all sync.
// RQ10 - The channel 0 mask releases that divider and ignores all sync.
// RQ11 - The sync masks never enable any output driver.
// RQ12 - Sync source clear fires on the next update, set uses the reference.
// RQ13 - Sync waits for a calibrated, locked loop unless overridden.
// RQ14 - Auto sync codes are off, frequency lock, phase lock and reserved.
// RQ15 - With auto sync off, software starts sync by command or masks.
// RQ16 - Control fields are staged and take effect only on the update.
// RQ17 - Auto sync fires once per rising edge of the selected lock.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
module rfd_divider_sync_top
    import rfd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic output_analog_loop_fb_detected,
    input wire logic output_analog_loop_calibrated,
    input wire logic output_analog_loop_locked,
    input wire logic digital_tracking_loop_freq_lock,
    input wire logic digital_tracking_loop_phase_lock,
    input wire logic ref_sync_in,
    output logic [3:0] first_prescaler_ratio,
    output logic first_prescaler_reset,
    output logic first_prescaler_powerdown,
    output logic second_prescaler_powerdown,
    output logic ch0_static_hold,
    output logic ch0_div_sync,
    output logic ch1_static_hold,
    output logic ch1_div_sync
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [5:0] raw_in;
    logic [5:0] sync_in;
    logic fb_det_s;
    logic cal_s;
    logic lock_s;
    logic freq_s;
    logic phase_s;
    logic ref_s;

    assign raw_in = {ref_sync_in, digital_tracking_loop_phase_lock,
                     digital_tracking_loop_freq_lock,
                     output_analog_loop_locked,
                     output_analog_loop_calibrated,
                     output_analog_loop_fb_detected};

    rfd_sync3 #(.W(6)) u_in_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(raw_in),
        .dout(sync_in)
    );

    assign fb_det_s = sync_in[0];
    assign cal_s = sync_in[1];
    assign lock_s = sync_in[2];
    assign freq_s = sync_in[3];
    assign phase_s = sync_in[4];
    assign ref_s = sync_in[5];

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic ack_ff;
    logic [31:0] rd_ff;
    logic bus_req;
    logic bus_wr;
    logic [15:0] bus_idx;
    logic hit_upd;
    logic hit_loop;
    logic hit_ratio;
    logic hit_pwr;
    logic hit_sync;
    logic hit_stat;
    logic hit_cmd;
    logic upd;
    logic manual_cmd;
    logic [7:0] rd_byte;
    logic [7:0] status;

    logic [7:0] stg_loop_ff;
    logic [7:0] stg_ratio_ff;
    logic [7:0] stg_pwr_ff;
    logic [7:0] stg_sync_ff;
    logic [7:0] act_loop_ff;
    logic [7:0] act_ratio_ff;
    logic [7:0] act_pwr_ff;
    logic [7:0] act_sync_ff;
    logic [7:0] nxt_loop;
    logic [7:0] nxt_ratio;
    logic [7:0] nxt_pwr;
    logic [7:0] nxt_sync;

    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_idx = wb_adr_i[17:2];
    // Writes land on the edge at which the master samples ack.
    assign bus_wr = bus_req & ack_ff & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i[1:0] == 2'b00);
    assign hit_upd = bus_idx == RFD_IDX_UPDATE;
    assign hit_loop = bus_idx == RFD_IDX_LOOP_CTL;
    assign hit_ratio = bus_idx == RFD_IDX_RATIO;
    assign hit_pwr = bus_idx == RFD_IDX_POWER;
    assign hit_sync = bus_idx == RFD_IDX_SYNC;
    assign hit_stat = bus_idx == RFD_IDX_STATUS;
    assign hit_cmd = bus_idx == RFD_IDX_CMD;
    assign upd = bus_wr & hit_upd
                 & (wb_dat_i[7:0] == RFD_UPDATE_CODE); // [RQ3]
    assign manual_cmd = bus_wr & hit_cmd & wb_dat_i[RFD_CMD_SYNC]; // [RQ15]

    assign nxt_loop = (wb_dat_i[7:0] & RFD_WM_LOOP_CTL)
                      | (RFD_RST_LOOP_CTL & ~RFD_WM_LOOP_CTL);
    assign nxt_ratio = wb_dat_i[7:0] & RFD_WM_RATIO;
    assign nxt_pwr = wb_dat_i[7:0] & RFD_WM_POWER;
    assign nxt_sync = wb_dat_i[7:0] & RFD_WM_SYNC;

    // Reads return the staged values or the live status; unmapped, update
    // and command registers read as zero.
    assign rd_byte = hit_loop ? stg_loop_ff :
                     hit_ratio ? stg_ratio_ff :
                     hit_pwr ? stg_pwr_ff :
                     hit_sync ? stg_sync_ff :
                     hit_stat ? status : 8'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            rd_ff <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_ff;

    // ------------------------------------------------------------------
    // Staging and active registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stg_loop_ff <= RFD_RST_LOOP_CTL;
            stg_ratio_ff <= RFD_RST_RATIO;
            stg_pwr_ff <= RFD_RST_POWER;
            stg_sync_ff <= RFD_RST_SYNC;
        end else begin
            if (bus_wr && hit_loop) begin
                stg_loop_ff <= nxt_loop;
            end
            if (bus_wr && hit_ratio) begin
                stg_ratio_ff <= nxt_ratio;
            end
            if (bus_wr && hit_pwr) begin
                stg_pwr_ff <= nxt_pwr;
            end
            if (bus_wr && hit_sync) begin
                stg_sync_ff <= nxt_sync;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_loop_ff <= RFD_RST_LOOP_CTL;
            act_ratio_ff <= RFD_RST_RATIO;
            act_pwr_ff <= RFD_RST_POWER;
            act_sync_ff <= RFD_RST_SYNC;
        end else if (upd) begin // [RQ16]
            act_loop_ff <= stg_loop_ff;
            act_ratio_ff <= stg_ratio_ff;
            act_pwr_ff <= stg_pwr_ff;
            act_sync_ff <= stg_sync_ff;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler ratio and power
    // ------------------------------------------------------------------
    logic [3:0] ratio_out_ff;
    logic pre1_rst_ff;
    logic pre1_pd_ff;
    logic pre2_pd_ff;
    logic [3:0] nxt_ratio_val;
    logic nxt_pre1_rst;
    logic startup_wait;

    // Undefined codes also hold the prescaler in reset as the safe choice.
    always_comb begin
        nxt_ratio_val = 4'h0;
        nxt_pre1_rst = 1'b0;
        case (act_ratio_ff[3:0])
            4'h0, 4'h1: nxt_ratio_val = 4'h3;
            4'h2: nxt_ratio_val = 4'h4;
            4'h3: nxt_ratio_val = 4'h5;
            4'h4: nxt_ratio_val = 4'h6;
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
                nxt_ratio_val = act_ratio_ff[3:0] + 4'h2; // [RQ1]
            end
            default: nxt_pre1_rst = 1'b1; // [RQ1]
        endcase
    end

    // Safe reprogramming relies on software passing through the hold code.
    // [RQ2] [RQ4]
    assign startup_wait = ~act_pwr_ff[RFD_PWR_STARTUP] & ~fb_det_s; // [RQ5]

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ratio_out_ff <= 4'h6;
            pre1_rst_ff <= 1'b0;
            pre1_pd_ff <= 1'b1;
            pre2_pd_ff <= 1'b1;
        end else begin
            ratio_out_ff <= nxt_ratio_val;
            pre1_rst_ff <= nxt_pre1_rst;
            pre1_pd_ff <= act_pwr_ff[RFD_PWR_DUAL] // [RQ6]
                          | act_pwr_ff[RFD_PWR_PD1] | startup_wait; // [RQ7]
            pre2_pd_ff <= act_pwr_ff[RFD_PWR_DUAL]
                          | act_pwr_ff[RFD_PWR_PD2] | startup_wait; // [RQ7]
        end
    end

    assign first_prescaler_ratio = ratio_out_ff;
    assign first_prescaler_reset = pre1_rst_ff;
    assign first_prescaler_powerdown = pre1_pd_ff;
    assign second_prescaler_powerdown = pre2_pd_ff;

    // ------------------------------------------------------------------
    // Distribution sync
    // ------------------------------------------------------------------
    logic lock_prev_ff;
    logic ref_prev_ff;
    logic pend_ff;
    logic fire_ff;
    logic gate;
    logic lock_sel;
    logic auto_evt;
    logic ref_evt;
    logic direct_evt;
    logic any_evt;

    assign gate = act_loop_ff[RFD_LOOP_OVR] | (cal_s & lock_s); // [RQ13]
    assign lock_sel = (act_sync_ff[1:0] == RFD_AUTO_FREQ) ? freq_s :
                      (act_sync_ff[1:0] == RFD_AUTO_PHASE) ? phase_s
                      : 1'b0; // [RQ14]
    assign auto_evt = lock_sel & ~lock_prev_ff; // [RQ17]
    assign ref_evt = act_sync_ff[RFD_SYNC_SRC] & ref_s & ~ref_prev_ff;
    assign direct_evt = upd & ~stg_sync_ff[RFD_SYNC_SRC]; // [RQ12]
    assign any_evt = direct_evt | ref_evt | auto_evt | manual_cmd;

    // A withheld sync is kept pending until the loop is ready.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_prev_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
            pend_ff <= 1'b0;
            fire_ff <= 1'b0;
        end else begin
            lock_prev_ff <= lock_sel;
            ref_prev_ff <= ref_s;
            pend_ff <= (any_evt | pend_ff) & ~gate;
            fire_ff <= (any_evt | pend_ff) & gate; // [RQ13]
        end
    end

    // ------------------------------------------------------------------
    // Channel dividers
    // ------------------------------------------------------------------
    rfd_chan_if ch0_if ();
    rfd_chan_if ch1_if ();

    // The masks feed only the divider gates, never a driver enable.
    assign ch0_if.sync_evt = fire_ff;
    assign ch0_if.mask = act_sync_ff[RFD_SYNC_MASK0]; // [RQ10] [RQ11]
    assign ch1_if.sync_evt = fire_ff;
    assign ch1_if.mask = act_sync_ff[RFD_SYNC_MASK1]; // [RQ9] [RQ11]

    rfd_chan_sync u_ch0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ch(ch0_if.chan)
    );

    rfd_chan_sync u_ch1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ch(ch1_if.chan)
    );

    assign ch0_static_hold = ch0_if.hold;
    assign ch0_div_sync = ch0_if.div_sync;
    assign ch1_static_hold = ch1_if.hold;
    assign ch1_div_sync = ch1_if.div_sync;

    assign status = {~ch1_if.hold, ~ch0_if.hold, pend_ff, phase_s,
                     freq_s, lock_s, cal_s, fb_det_s};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ratio_step: assert property ( // [RQ1]
        (act_ratio_ff[3:0] >= 4'h5 && act_ratio_ff[3:0] <= 4'h9)
        |=> ratio_out_ff == $past(act_ratio_ff[3:0]) + 4'h2 && !pre1_rst_ff)
        else $error("prescaler ratio decode wrong");
    a_ratio_hold: assert property ( // [RQ1]
        act_ratio_ff[3:0] == RFD_RATIO_HOLD |=> pre1_rst_ff)
        else $error("hold code did not reset the prescaler");
    a_update_load: assert property ( // [RQ3]
        upd |=> act_pwr_ff == $past(stg_pwr_ff)
        && act_sync_ff == $past(stg_sync_ff))
        else $error("update strobe did not load staged values");
    a_stage_hold: assert property ( // [RQ16]
        !upd |=> $stable(act_pwr_ff) && $stable(act_sync_ff)
        && $stable(act_ratio_ff) && $stable(act_loop_ff))
        else $error("active control changed without update");
    a_startup_wait: assert property ( // [RQ5]
        (!act_pwr_ff[RFD_PWR_STARTUP] && !fb_det_s)
        |=> pre1_pd_ff && pre2_pd_ff)
        else $error("prescalers ran before feedback was detected");
    a_dual_pd: assert property ( // [RQ6]
        act_pwr_ff[RFD_PWR_DUAL] |=> pre1_pd_ff && pre2_pd_ff)
        else $error("dual power-down not applied");
    a_second_pd: assert property ( // [RQ7]
        act_pwr_ff[RFD_PWR_PD2] |=> pre2_pd_ff)
        else $error("second prescaler not powered down");
    a_first_on: assert property ( // [RQ7]
        (!act_pwr_ff[RFD_PWR_DUAL] && !act_pwr_ff[RFD_PWR_PD1]
        && (act_pwr_ff[RFD_PWR_STARTUP] || fb_det_s)) |=> !pre1_pd_ff)
        else $error("first prescaler powered down while enabled");
    a_lock_gate: assert property ( // [RQ13]
        !gate |=> !fire_ff)
        else $error("sync fired while loop not ready");
    a_direct_sync: assert property ( // [RQ12]
        (upd && !stg_sync_ff[RFD_SYNC_SRC] && gate) |=> fire_ff ##1 1'b1)
        else $error("direct sync did not follow the update");
    a_auto_freq: assert property ( // [RQ14]
        (act_sync_ff[1:0] == RFD_AUTO_FREQ
        && $past(act_sync_ff[1:0]) == RFD_AUTO_FREQ
        && freq_s && !$past(freq_s) && gate) |=> fire_ff)
        else $error("frequency lock did not trigger sync");
    a_auto_once: assert property ( // [RQ17]
        (lock_sel && lock_prev_ff && gate && !pend_ff && !upd
        && !manual_cmd && !ref_evt) |=> !fire_ff)
        else $error("steady lock produced a repeated sync");
endmodule : rfd_divider_sync_top

// [logic/rfd_sync3.sv]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module rfd_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    // A bit changes only once the second and third stages agree.
    assign nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));
    assign dout = out_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule : rfd_sync3

// [sim/rfd_divider_sync_top_tb_top.sv]
// Self-checking bench for the prescaler and distribution sync block.
`timescale 1ns/10ps
module rfd_divider_sync_top_tb_top
    import rfd_pkg::*;
;
// --------------------
// Signals
// --------------------
logic clk = 1'b0;
logic sys_rst = 1'b1;
logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
logic [17:0] wb_adr = '0;
logic [3:0] wb_sel = 4'h0;
logic [31:0] wb_wdat = '0;
logic [31:0] wb_rdat;
logic wb_ack;
logic fb_det = 1'b0, loop_cal = 1'b0, loop_lock = 1'b0;
logic f_lock = 1'b0, p_lock = 1'b0, ref_in = 1'b0;
logic [3:0] ratio;
logic p1_rst, p1_pd, p2_pd, h0, s0, h1, s1;
logic [7:0] v, pv;
logic [31:0] rd;
int mismatches = 0;
int compares = 0;
int c0, c1;

always #4 clk = ~clk;

rfd_divider_sync_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .output_analog_loop_fb_detected(fb_det),
    .output_analog_loop_calibrated(loop_cal),
    .output_analog_loop_locked(loop_lock),
    .digital_tracking_loop_freq_lock(f_lock),
    .digital_tracking_loop_phase_lock(p_lock),
    .ref_sync_in(ref_in), .first_prescaler_ratio(ratio),
    .first_prescaler_reset(p1_rst), .first_prescaler_powerdown(p1_pd),
    .second_prescaler_powerdown(p2_pd), .ch0_static_hold(h0),
    .ch0_div_sync(s0), .ch1_static_hold(h1), .ch1_div_sync(s1)
);

// --------------------
// Tasks
// --------------------
task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask : wrap_up

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
        mismatches++;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
endtask : chk

task automatic cyc(input int n);
    repeat (n) @(posedge clk);
endtask : cyc

// Holds the request until ack is sampled high, then releases it.
task automatic wb(input logic we, input logic [15:0] idx,
                  input logic [7:0] d);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h1;
    wb_wdat <= {24'h0, d};
    n = 0;
    do begin
        @(posedge clk);
        n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
        mismatches++;
        wrap_up();
    end
endtask : wb

task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
endtask : wr

task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
endtask : rdc

task automatic upd();
    wr(RFD_IDX_UPDATE, RFD_UPDATE_CODE);
endtask : upd

task automatic count(input int n);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
        @(posedge clk);
        c0 += int'(s0 === 1'b1);
        c1 += int'(s1 === 1'b1);
    end
endtask : count

task automatic do_reset();
    sys_rst <= 1'b1;
    cyc(16);
    sys_rst <= 1'b0;
    @(posedge clk);
endtask : do_reset

// Expected {first, second} power-down levels for a power setting.
function automatic logic [1:0] pd_exp(input logic [7:0] p);
    logic w;
    w = !p[RFD_PWR_STARTUP] && !fb_det;
    return {p[0] | p[2] | w, p[1] | p[2] | w};
endfunction : pd_exp

// --------------------
// Sequence
// --------------------
initial begin
    void'($urandom(32'h69dbec21));
    do_reset();
    rdc(RFD_IDX_LOOP_CTL, 8'h20);
    rdc(RFD_IDX_RATIO, 8'h44);
    rdc(RFD_IDX_POWER, 8'h02);
    rdc(RFD_IDX_SYNC, 8'h02);
    rdc(RFD_IDX_UPDATE, 8'h00);
    rdc(16'h0123, 8'h00);
    wr(RFD_IDX_POWER, 8'hff);
    rdc(RFD_IDX_POWER, 8'h17);
    wr(RFD_IDX_LOOP_CTL, 8'hff);
    rdc(RFD_IDX_LOOP_CTL, 8'h28);
    v = {4'($urandom), 4'h7};
    wr(RFD_IDX_RATIO, v);
    rdc(RFD_IDX_RATIO, v);
    $display("test registers done");

    do_reset();
    pv = 8'h02;
    for (int i = 0; i < 12; i++) begin
        v = (i < 2) ? (i ? 8'h10 : 8'h04) : 8'($urandom) & RFD_WM_POWER;
        fb_det <= (i == 1) ? 1'b0 : 1'($urandom);
        wr(RFD_IDX_POWER, v);
        cyc(8);
        chk({p1_pd, p2_pd}, pd_exp(pv));
        upd();
        cyc(8);
        chk({p1_pd, p2_pd}, pd_exp(v));
        pv = v;
    end
    $display("test power done");

    do_reset();
    for (int c = 5; c <= 9; c++) begin
        wr(RFD_IDX_RATIO, {4'h4, RFD_RATIO_HOLD});
        upd();
        cyc(3);
        chk({p1_rst, ratio}, 5'h10);
        wr(RFD_IDX_RATIO, 8'(c));
        cyc(3);
        chk({p1_rst, ratio}, 5'h10);
        upd();
        cyc(3);
        chk({p1_rst, ratio}, 5'(c + 2));
    end
    // Direct ratio change, as when an oscillator calibration follows.
    wr(RFD_IDX_RATIO, 8'h06);
    upd();
    cyc(3);
    chk({p1_rst, ratio}, 5'h08);
    $display("test ratio done");

    do_reset();
    wr(RFD_IDX_SYNC, 8'h22);
    cyc(4);
    chk({h1, h0}, 2'b11);
    upd();
    count(20);
    chk({h1, h0}, 2'b01);
    chk(c0 + c1, 0);
    rdc(RFD_IDX_STATUS, {3'b101, 4'h0, fb_det});
    loop_cal <= 1'b1;
    loop_lock <= 1'b1;
    count(20);
    chk({h1, h0}, 2'b00);
    chk({c1[3:0], c0[3:0]}, 8'h01);
    rdc(RFD_IDX_STATUS, {2'b11, 3'b000, 2'b11, fb_det});
    upd();
    count(20);
    chk({c1[3:0], c0[3:0]}, 8'h01);
    $display("test mask one done");

    do_reset();
    wr(RFD_IDX_SYNC, 8'h14);
    upd();
    count(12);
    chk({h1, h0}, 2'b10);
    wr(RFD_IDX_CMD, 8'h01);
    count(20);
    chk({h1, c1[3:0], c0[3:0]}, 9'h010);
    $display("test mask zero done");

    for (int m = 0; m < 4; m++) begin
        do_reset();
        {loop_cal, loop_lock, f_lock, p_lock, ref_in} <= 5'h00;
        wr(RFD_IDX_LOOP_CTL, 8'h08);
        wr(RFD_IDX_SYNC, 8'(4 + m));
        upd();
        count(20);
        chk(c0, 0);
        f_lock <= 1'b1;
        count(20);
        chk(c0, 32'(m == 1));
        p_lock <= 1'b1;
        count(20);
        chk(c0, 32'(m == 2));
        ref_in <= 1'b1;
        count(20);
        chk({h1, c1[3:0]}, 5'h01);
    end
    $display("test auto sync done");
    wrap_up();
end
endmodule : rfd_divider_sync_top_tb_top
